// file: hw/qpr_pkg.sv
/*
  Shared constants for the quad-port RAM wrapper: default geometry, width
  limits of the two RAM variants, port indices and reset values.
  Assumes nothing of its surroundings; imported by every design module but not by the RAM interface.
*/
package qpr_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned DEF_DATA_W   = 16;   // Small variant, 256 x 16
  localparam int unsigned DEF_ADDR_W   = 8;
  localparam int unsigned LARGE_DATA_W = 18;   // Large variant, 1K x 18
  localparam int unsigned LARGE_ADDR_W = 10;
  localparam int unsigned MAX_W_SMALL  = 16;
  localparam int unsigned MAX_W_LARGE  = 36;   // Parity bits included

  // ****************************************************************
  // Port indices and pairing
  // ****************************************************************
  localparam int unsigned NUM_PAIRS = 2;
  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned PORT_A    = 0;
  localparam int unsigned PORT_B    = 1;
  localparam int unsigned PORT_C    = 2;
  localparam int unsigned PORT_D    = 3;

  // ****************************************************************
  // Select encoding and reset values
  // ****************************************************************
  localparam logic SEL_FIRST = 1'b1;  // First port of the pair owns the RAM
  localparam logic SEL_RESET = 1'b0;

endpackage : qpr_pkg

// file: hw/qpr_ram_if.sv
/*
  One physical RAM port as seen between the slot multiplexer and the RAM.
  Assumes both ends run on the doubled clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface qpr_ram_if #(
  parameter int unsigned DATA_W = 16,
  parameter int unsigned ADDR_W = 8
);
  logic              we;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wrData;
  logic [DATA_W-1:0] rdData;

  modport ctrl (output we, output addr, output wrData, input rdData);
  modport ram  (input we, input addr, input wrData, output rdData);
endinterface : qpr_ram_if

`default_nettype wire

// file: hw/qpr_phase_sel.sv
/*
  Slot select for one port pair: the pair's system clock, seen as a level,
  is inverted and registered by the doubled clock.
  Assumes the system clock level is phase aligned to clk at half its rate.
*/
`timescale 1ns/100ps
`default_nettype none

module qpr_phase_sel
  import qpr_pkg::*;
(
  input  wire logic clk,        // Doubled clock
  input  wire logic rst,        // Synchronous reset, active high
  input  wire logic pairSysClk, // Pair system clock as a level
  output var  logic selFirst    // High while the first port owns the RAM
);

  typedef struct packed {
    logic selFirst;
  } qpr_sel_t;

  qpr_sel_t st_r;
  qpr_sel_t st_nxt;

  // ****************************************************************
  // Select register
  // ****************************************************************
  // The system clock feeds only this one flip-flop, keeping the clock tree light
  always_comb begin
    st_nxt          = st_r;
    st_nxt.selFirst = ~pairSysClk;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r.selFirst <= SEL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign selFirst = st_r.selFirst;

  sel_tracks_clk_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> (selFirst == !$past(pairSysClk)))
    else $error("select does not follow inverted system clock");

endmodule : qpr_phase_sel

`default_nettype wire

// file: hw/qpr_dp_ram.sv
/*
  True dual-port RAM in flip-flops, both ports on the doubled clock.
  Each port reads the old contents on a write. Assumes the user never
  touches one address from both ports in the same slot.
*/
`timescale 1ns/100ps
`default_nettype none

module qpr_dp_ram
  import qpr_pkg::*;
#(
  parameter int unsigned DATA_W = DEF_DATA_W,
  parameter int unsigned ADDR_W = DEF_ADDR_W
) (
  input  wire logic clk,    // Doubled clock
  input  wire logic rst,    // Synchronous reset, active high
  qpr_ram_if.ram    portAc, // Physical port of pair A/C
  qpr_ram_if.ram    portBd  // Physical port of pair B/D
);

  localparam int unsigned DEPTH = 1 << ADDR_W;

  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0]            rdAc;
    logic [DATA_W-1:0]            rdBd;
  } qpr_ram_t;

  qpr_ram_t st_r;
  qpr_ram_t st_nxt;

  // ****************************************************************
  // Array access
  // ****************************************************************
  // Same-address collisions are not arbitrated; port B/D simply lands last
  always_comb begin
    st_nxt      = st_r;
    st_nxt.rdAc = st_r.mem[portAc.addr];
    st_nxt.rdBd = st_r.mem[portBd.addr];
    if (portAc.we) begin
      st_nxt.mem[portAc.addr] = portAc.wrData;
    end
    if (portBd.we) begin
      st_nxt.mem[portBd.addr] = portBd.wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign portAc.rdData = st_r.rdAc;
  assign portBd.rdData = st_r.rdBd;

  write_read_back_a: assert property (@(posedge clk) disable iff (rst)
    (portAc.we && !(portBd.we && portBd.addr == portAc.addr)) ##1
    (!portAc.we && portAc.addr == $past(portAc.addr))
    |=> (portAc.rdData == $past(portAc.wrData, 2)))
    else $error("written word not read back on A/C port");

endmodule : qpr_dp_ram

`default_nettype wire

// file: hw/qpr_quad_port_ram.sv
/*
  Quad-port RAM wrapper: four user ports A, B, C, D share one true dual-port
  RAM. Ports A and C take turns on one physical port, B and D on the other.
  Assumes sys_clk is the doubled clock and that each pair's system clock
  arrives as a phase-aligned level at half that rate.
*/
`timescale 1ns/100ps
`default_nettype none

module qpr_quad_port_ram
  import qpr_pkg::*;
#(
  parameter int unsigned DATA_W    = DEF_DATA_W, // Port data width
  parameter int unsigned ADDR_W    = DEF_ADDR_W, // Port address width
  parameter bit          LARGE_RAM = 1'b0        // Selects the 36-bit width limit
) (
  input  wire logic              sys_clk,          // Doubled clock for both pairs
  input  wire logic              rst,              // Synchronous reset, active high
  input  wire logic              pairAcSystemClock, // A/C system clock as a level
  input  wire logic              pairBdSystemClock, // B/D system clock as a level
  input  wire logic              portAWrEn,        // Port A write enable
  input  wire logic [ADDR_W-1:0] portAAddr,        // Port A address
  input  wire logic [DATA_W-1:0] portAWrData,      // Port A write data
  output var  logic [DATA_W-1:0] portARdData,      // Port A held read data
  input  wire logic              portBWrEn,        // Port B write enable
  input  wire logic [ADDR_W-1:0] portBAddr,        // Port B address
  input  wire logic [DATA_W-1:0] portBWrData,      // Port B write data
  output var  logic [DATA_W-1:0] portBRdData,      // Port B held read data
  input  wire logic              portCWrEn,        // Port C write enable
  input  wire logic [ADDR_W-1:0] portCAddr,        // Port C address
  input  wire logic [DATA_W-1:0] portCWrData,      // Port C write data
  output var  logic [DATA_W-1:0] portCRdData,      // Port C held read data
  input  wire logic              portDWrEn,        // Port D write enable
  input  wire logic [ADDR_W-1:0] portDAddr,        // Port D address
  input  wire logic [DATA_W-1:0] portDWrData,      // Port D write data
  output var  logic [DATA_W-1:0] portDRdData       // Port D held read data
);

  // ****************************************************************
  // Width limits
  // ****************************************************************
  localparam int unsigned MAX_W = LARGE_RAM ? MAX_W_LARGE : MAX_W_SMALL;

  // ****************************************************************
  // Port gathering
  // ****************************************************************
  logic [NUM_PAIRS-1:0] sysClkArr;
  logic [NUM_PORTS-1:0] wrEnArr;
  logic [ADDR_W-1:0]    addrArr   [NUM_PORTS];
  logic [DATA_W-1:0]    wrDataArr [NUM_PORTS];
  logic [DATA_W-1:0]    rdDataArr [NUM_PORTS];
  logic [NUM_PAIRS-1:0] selArr;

  // A and C follow the first system clock, B and D the second
  assign sysClkArr[0] = pairAcSystemClock;
  assign sysClkArr[1] = pairBdSystemClock;

  assign wrEnArr[PORT_A]   = portAWrEn;
  assign wrEnArr[PORT_B]   = portBWrEn;
  assign wrEnArr[PORT_C]   = portCWrEn;
  assign wrEnArr[PORT_D]   = portDWrEn;
  assign addrArr[PORT_A]   = portAAddr;
  assign addrArr[PORT_B]   = portBAddr;
  assign addrArr[PORT_C]   = portCAddr;
  assign addrArr[PORT_D]   = portDAddr;
  assign wrDataArr[PORT_A] = portAWrData;
  assign wrDataArr[PORT_B] = portBWrData;
  assign wrDataArr[PORT_C] = portCWrData;
  assign wrDataArr[PORT_D] = portDWrData;

  // Hold registers drive the outputs directly
  assign portARdData = rdDataArr[PORT_A];
  assign portBRdData = rdDataArr[PORT_B];
  assign portCRdData = rdDataArr[PORT_C];
  assign portDRdData = rdDataArr[PORT_D];

  // ****************************************************************
  // Shared array
  // ****************************************************************
  qpr_ram_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) ramPort [NUM_PAIRS] ();

  // Both physical ports run on the doubled clock
  qpr_dp_ram #(
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W)
  ) u_ram (
    .clk    (sys_clk),
    .rst    (rst),
    .portAc (ramPort[0]),
    .portBd (ramPort[1])
  );

  // ****************************************************************
  // Per-pair slot multiplexer and hold registers
  // ****************************************************************
  for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_pair
    localparam int unsigned FIRST  = g;
    localparam int unsigned SECOND = g + NUM_PAIRS;

    typedef struct packed {
      logic [DATA_W-1:0] holdFirst;
      logic [DATA_W-1:0] holdSecond;
    } qpr_hold_t;

    qpr_hold_t st_r;
    qpr_hold_t st_nxt;

    qpr_phase_sel u_sel (
      .clk        (sys_clk),
      .rst        (rst),
      .pairSysClk (sysClkArr[g]),
      .selFirst   (selArr[g])
    );

    // One select moves every field of a request, so a slot never mixes ports.
    // User requests change only at the system rising edge, so each stands
    // stable through both slots of its cycle.
    always_comb begin
      if (selArr[g] == SEL_FIRST) begin
        ramPort[g].we     = wrEnArr[FIRST];
        ramPort[g].addr   = addrArr[FIRST];
        ramPort[g].wrData = wrDataArr[FIRST];
      end else begin
        ramPort[g].we     = wrEnArr[SECOND];
        ramPort[g].addr   = addrArr[SECOND];
        ramPort[g].wrData = wrDataArr[SECOND];
      end
    end

    // The RAM output lags its slot by one doubled cycle, so each hold
    // register samples during the other port's slot
    always_comb begin
      st_nxt = st_r;
      if (selArr[g] != SEL_FIRST) begin
        st_nxt.holdFirst = ramPort[g].rdData;
      end else begin
        st_nxt.holdSecond = ramPort[g].rdData;
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        st_r <= '0;
      end else begin
        st_r <= st_nxt;
      end
    end

    assign rdDataArr[FIRST]  = st_r.holdFirst;
    assign rdDataArr[SECOND] = st_r.holdSecond;

    // ****************************************************************
    // Checks
    // ****************************************************************
    first_slot_route_a: assert property (@(posedge sys_clk) disable iff (rst)
      (selArr[g] == SEL_FIRST) |-> (ramPort[g].addr == addrArr[FIRST]
        && ramPort[g].we == wrEnArr[FIRST] && ramPort[g].wrData == wrDataArr[FIRST]))
      else $error("first port not routed in first slot");

    second_slot_route_a: assert property (@(posedge sys_clk) disable iff (rst)
      (selArr[g] != SEL_FIRST) |-> (ramPort[g].addr == addrArr[SECOND]
        && ramPort[g].we == wrEnArr[SECOND] && ramPort[g].wrData == wrDataArr[SECOND]))
      else $error("second port not routed in second slot");

    first_hold_load_a: assert property (@(posedge sys_clk) disable iff (rst)
      (selArr[g] != SEL_FIRST) |=> (rdDataArr[FIRST] == $past(ramPort[g].rdData)))
      else $error("first port hold register missed its load");

    first_hold_stable_a: assert property (@(posedge sys_clk) disable iff (rst)
      (selArr[g] == SEL_FIRST) |=> $stable(rdDataArr[FIRST]))
      else $error("first port result changed mid cycle");

    second_hold_load_a: assert property (@(posedge sys_clk) disable iff (rst)
      (selArr[g] == SEL_FIRST) |=> (rdDataArr[SECOND] == $past(ramPort[g].rdData)))
      else $error("second port hold register missed its load");

    second_hold_stable_a: assert property (@(posedge sys_clk) disable iff (rst)
      (selArr[g] != SEL_FIRST) |=> $stable(rdDataArr[SECOND]))
      else $error("second port result changed mid cycle");

    read_latency_a: assert property (@(posedge sys_clk) disable iff (rst)
      (selArr[g] == SEL_FIRST && !wrEnArr[FIRST]) ##1 (selArr[g] != SEL_FIRST) ##1 1'b1
      |-> (rdDataArr[FIRST] == $past(ramPort[g].rdData)))
      else $error("first port read result not presented after two cycles");

    slot_alternate_a: assert property (@(posedge sys_clk) disable iff (rst)
      (sysClkArr[g] != $past(sysClkArr[g])) ##1 (sysClkArr[g] != $past(sysClkArr[g]))
      |-> (selArr[g] != $past(selArr[g])))
      else $error("slot select does not alternate with system clock");

    first_write_c: cover property (@(posedge sys_clk) disable iff (rst)
      (selArr[g] == SEL_FIRST && wrEnArr[FIRST]));
    second_write_c: cover property (@(posedge sys_clk) disable iff (rst)
      (selArr[g] != SEL_FIRST && wrEnArr[SECOND]));
    both_read_c: cover property (@(posedge sys_clk) disable iff (rst)
      (selArr[g] == SEL_FIRST && !wrEnArr[FIRST]) ##1 (!wrEnArr[SECOND]) ##2 1'b1);
  end : g_pair

  // ****************************************************************
  // Configuration check and cross-pair cover
  // ****************************************************************
  width_limit_a: assert property (@(posedge sys_clk) disable iff (rst)
    (DATA_W <= MAX_W) && (DATA_W >= 1))
    else $error("port data width exceeds the RAM variant limit");

  cross_pair_c: cover property (@(posedge sys_clk) disable iff (rst)
    (wrEnArr[PORT_A] && wrEnArr[PORT_B]));

endmodule : qpr_quad_port_ram

`default_nettype wire

// file: verif/qpr_user_model.sv
/*
  User-side model for the quad-port RAM wrapper: makes both pair system
  clock levels and launches staged port requests at each pair's rising edge.
  Assumes the bench stages a request, then toggles that pair's request flag.
*/
`timescale 1ns/100ps
`default_nettype none

module qpr_user_model
  import qpr_pkg::*;
#(
  parameter int unsigned DATA_W = DEF_DATA_W,
  parameter int unsigned ADDR_W = DEF_ADDR_W
) (
  input  wire logic              sys_clk,    // Doubled clock
  input  wire logic              rst,        // Synchronous reset, active high
  input  wire logic [1:0]        reqTog,     // Toggles once per staged request, bit per pair
  input  wire logic [3:0]        stWe,       // Staged write enables, index is the port
  input  wire logic [ADDR_W-1:0] stAddr [4], // Staged addresses
  input  wire logic [DATA_W-1:0] stData [4], // Staged write data
  output var  logic [1:0]        launch,     // High for one cycle after a pair launches
  output var  logic [1:0]        sysLvl,     // Bit 0 is the A/C level, bit 1 the B/D level
  output var  logic [3:0]        we,         // Write enables to the wrapper
  output var  logic [ADDR_W-1:0] addr [4],   // Addresses to the wrapper
  output var  logic [DATA_W-1:0] data [4]    // Write data to the wrapper
);
  logic [1:0] ackTog;

  // ****************************************************************
  // Levels and request launch
  // ****************************************************************
  initial begin
    sysLvl = 2'h2;
    ackTog = 2'h0;
    launch = 2'h0;
    we     = 4'h0;
    for (int i = 0; i < 4; i++) begin
      addr[i] = '0;
      data[i] = '0;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      sysLvl <= 2'h2;  // B/D runs one doubled cycle away from A/C
      ackTog <= 2'h0;
      launch <= 2'h0;
      we     <= 4'h0;
    end else begin
      sysLvl <= ~sysLvl;
      for (int p = 0; p < 2; p++) begin
        launch[p] <= 1'b0;
        if (!sysLvl[p]) begin
          if (reqTog[p] != ackTog[p]) begin
            ackTog[p] <= reqTog[p];
            launch[p] <= 1'b1;
            for (int q = p; q < 4; q += 2) begin
              we[q]   <= stWe[q];
              addr[q] <= stAddr[q];
              data[q] <= stData[q];
            end
          end else begin
            we[p]   <= 1'b0;  // An idle slot never repeats an old write
            we[p+2] <= 1'b0;
          end
        end
      end
    end
  end
endmodule : qpr_user_model

`default_nettype wire

// file: verif/tb_qpr_quad_port_ram.sv
/*
  Self-checking bench for the quad-port RAM wrapper, 256 x 16 geometry.
  Assumes the user model launches each staged request at a system rising edge.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_qpr_quad_port_ram;
  import qpr_pkg::*;
  localparam int unsigned DW = DEF_DATA_W;
  localparam int unsigned AW = DEF_ADDR_W;

  logic          sys_clk;
  logic          rst;
  logic [1:0]    reqTog;
  logic [3:0]    stWe;
  logic [AW-1:0] stAddr [4];
  logic [DW-1:0] stData [4];
  logic [1:0]    launch;
  logic [1:0]    sysLvl;
  logic [3:0]    we;
  logic [AW-1:0] addr [4];
  logic [DW-1:0] data [4];
  logic [DW-1:0] rd [4];
  int            err_total;
  int            compares;
  int            cycles;

  qpr_user_model #(.DATA_W(DW), .ADDR_W(AW)) i_user (.sys_clk(sys_clk), .rst(rst), .reqTog(reqTog),
    .stWe(stWe), .stAddr(stAddr), .stData(stData), .launch(launch), .sysLvl(sysLvl), .we(we),
    .addr(addr), .data(data));

  qpr_quad_port_ram #(.DATA_W(DW), .ADDR_W(AW), .LARGE_RAM(1'b0)) i_dut (.sys_clk(sys_clk), .rst(rst),
    .pairAcSystemClock(sysLvl[0]), .pairBdSystemClock(sysLvl[1]),
    .portAWrEn(we[PORT_A]), .portAAddr(addr[PORT_A]), .portAWrData(data[PORT_A]), .portARdData(rd[PORT_A]),
    .portBWrEn(we[PORT_B]), .portBAddr(addr[PORT_B]), .portBWrData(data[PORT_B]), .portBRdData(rd[PORT_B]),
    .portCWrEn(we[PORT_C]), .portCAddr(addr[PORT_C]), .portCWrData(data[PORT_C]), .portCRdData(rd[PORT_C]),
    .portDWrEn(we[PORT_D]), .portDAddr(addr[PORT_D]), .portDWrData(data[PORT_D]), .portDRdData(rd[PORT_D]));

  // ****************************************************************
  // Clock, timeout and common tasks
  // ****************************************************************
  always #2 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin  // Whole run needs about 85 cycles
      err_total++;
      finish_test();
    end
  end

  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // One system cycle on pair p: first port p, second port p+2; entered at a sys_clk rising edge
  task automatic doPair(input int p, input logic weF, input logic [AW-1:0] aF, input logic [DW-1:0] dF,
                        input logic weS, input logic [AW-1:0] aS, input logic [DW-1:0] dS,
                        input logic [DW-1:0] expF, input logic [DW-1:0] expS);
    int n;
    stWe[p]     <= weF;
    stAddr[p]   <= aF;
    stData[p]   <= dF;
    stWe[p+2]   <= weS;
    stAddr[p+2] <= aS;
    stData[p+2] <= dS;
    reqTog[p]   <= ~reqTog[p];
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (launch[p] !== 1'b1 && n < 10);
    check({{(DW-1){1'b0}}, launch[p]}, 16'h0001);
    repeat (2) @(negedge sys_clk);
    check(rd[p], expF);
    @(negedge sys_clk);
    check(rd[p+2], expS);
    check(rd[p], expF);
    @(posedge sys_clk);
  endtask : doPair

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic testReset();
    @(negedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      check(rd[i], 16'h0000);
    end
    @(posedge sys_clk);
    doPair(0, 1'b0, 8'h11, 16'h0000, 1'b0, 8'hFF, 16'h0000, 16'h0000, 16'h0000);
    doPair(1, 1'b0, 8'h00, 16'h0000, 1'b0, 8'h80, 16'h0000, 16'h0000, 16'h0000);
    $display("testReset done");
  endtask : testReset

  task automatic testWriteRead();
    doPair(0, 1'b1, 8'h10, 16'h1234, 1'b1, 8'hFF, 16'hFFFF, 16'h0000, 16'h0000);
    doPair(0, 1'b0, 8'hFF, 16'h0000, 1'b0, 8'h10, 16'h0000, 16'hFFFF, 16'h1234);
    doPair(0, 1'b0, 8'h10, 16'hDEAD, 1'b1, 8'h30, 16'h5A5A, 16'h1234, 16'h0000);
    doPair(0, 1'b0, 8'h30, 16'h0000, 1'b0, 8'h10, 16'h0000, 16'h5A5A, 16'h1234);
    doPair(1, 1'b0, 8'h10, 16'h0000, 1'b0, 8'hFF, 16'h0000, 16'h1234, 16'hFFFF);
    $display("testWriteRead done");
  endtask : testWriteRead

  task automatic testReadOld();
    // Read then write, then write then read, of one address in separate slots of one cycle
    doPair(0, 1'b0, 8'h05, 16'h0000, 1'b1, 8'h05, 16'hBEEF, 16'h0000, 16'h0000);
    doPair(0, 1'b1, 8'h05, 16'h7777, 1'b0, 8'h05, 16'h0000, 16'hBEEF, 16'h7777);
    $display("testReadOld done");
  endtask : testReadOld

  task automatic testPairBd();
    doPair(1, 1'b1, 8'h40, 16'h0F0F, 1'b1, 8'h41, 16'hF0F0, 16'h0000, 16'h0000);
    doPair(1, 1'b0, 8'h41, 16'h0000, 1'b1, 8'h40, 16'hA5A5, 16'hF0F0, 16'h0F0F);
    doPair(0, 1'b0, 8'h40, 16'h0000, 1'b0, 8'h41, 16'h0000, 16'hA5A5, 16'hF0F0);
    $display("testPairBd done");
  endtask : testPairBd

  initial begin
    sys_clk   = 1'b0;
    rst       = 1'b1;
    reqTog    = 2'h0;
    stWe      = 4'h0;
    err_total = 0;
    compares  = 0;
    cycles    = 0;
    for (int i = 0; i < 4; i++) begin
      stAddr[i] = '0;
      stData[i] = '0;
    end
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    testReset();
    testWriteRead();
    testReadOld();
    testPairBd();
    finish_test();
  end
endmodule : tb_qpr_quad_port_ram

`default_nettype wire
